// ---- logic/meat_pkg.sv ----
package meat_pkg;
	// page table entry layout
	localparam int ENTRY_VALID_BIT = 0;
	localparam int ENTRY_WRITE_ENABLE_BIT = 1;
	localparam int ENTRY_PRIVILEGED_ONLY_BIT = 2;
	localparam int ENTRY_WRITE_MERGE_BIT = 3;
	localparam int ENTRY_EXCLUSIVE_SCOPE_BIT = 4;
	localparam int PTE_MODE_LSB = 6;
	localparam int PTE_BASE_LSB = 12;
	localparam int PAGE_MASK_W = 12;
	localparam int LOOKUP_FIRST_BIT = 2;
	localparam int GLOBAL_RANGE_BIT = 31;
	localparam int NUM_THREADS = 4;
	localparam logic [4:0] BYPASS_CTRL_BITS = 5'h03;
	localparam logic [7:0] MASK_TOP_KEEP = 8'hff;
	// configuration codes
	localparam logic [2:0] CFG_RESET = 3'h0;
	localparam logic [2:0] CFG_ENHANCED_BYPASS = 3'h6;
	localparam logic [2:0] CFG_ACTIVE = 3'h7;
	// register byte offsets
	localparam logic [11:0] OFS_TRANSLATION_MODE_CONFIG = 12'h000;
	localparam logic [11:0] OFS_LOCAL_BYPASS_CACHE_CTRL = 12'h004;
	localparam logic [11:0] OFS_GLOBAL_BYPASS_CACHE_CTRL = 12'h008;
	localparam logic [11:0] OFS_TLB_FLUSH = 12'h00c;
	localparam logic [11:0] OFS_STATUS = 12'h010;
	// idle cycles before an open merge buffer is sent
	localparam int MERGE_HOLD_CYCLES = 4;

	typedef enum logic [1:0] {
		cache_mode_uncached = 2'b00,
		cache_mode_transient = 2'b01,
		cache_mode_single_way = 2'b10,
		cache_mode_full = 2'b11
	} meat_cache_mode_t;
	typedef enum logic [1:0] {
		mmu_bypass = 2'b00,
		mmu_enhanced = 2'b01,
		mmu_active = 2'b10
	} meat_mmu_mode_t;
	typedef enum logic [2:0] {
		fault_none = 3'b000,
		fault_invalid = 3'b001,
		fault_write = 3'b010,
		fault_privileged_only = 3'b011,
		fault_read = 3'b100,
		fault_claim = 3'b101
	} meat_fault_t;
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_lookup = 2'b01,
		st_walk = 2'b10
	} meat_state_t;

	typedef struct packed {
		logic valid;
		logic lookup;
		logic write;
		logic privileged_only;
		logic claimed;
		logic [1:0] thread;
		logic [NUM_THREADS-1:0] lock_mask;
		logic [31:0] addr;
		logic [63:0] wdata;
		logic [7:0] be;
	} meat_req_t;
	typedef struct packed {
		logic valid;
		meat_fault_t fault;
		logic [31:0] paddr;
		logic burst_read;
		logic cache_alloc;
		logic alloc_transient;
		logic alloc_way_only;
		logic [1:0] alloc_way;
		logic write_merge_allowed;
		logic exclusive_system_scope;
		logic system_coherent_flag;
		logic [63:0] result;
	} meat_resp_t;
	typedef struct packed {
		logic valid;
		logic l1_valid;
		logic [31:0] pte;
		logic readable;
		logic single_use;
		logic [PAGE_MASK_W-1:0] mask;
	} meat_walk_t;
	typedef struct packed {
		logic [19:0] tag;
		logic [31:0] pte;
		logic readable;
		logic single_use;
		logic [PAGE_MASK_W-1:0] mask;
	} meat_tlb_ent_t;
	typedef struct packed {
		logic valid;
		logic [28:0] qaddr;
		logic [63:0] data;
		logic [7:0] be;
	} meat_wr_t;
endpackage

// ---- logic/meat_tlb_mem.sv ----
`timescale 1ns/10ps
module meat_tlb_mem #(
	parameter int W = 66,
	parameter int DEPTH = 16,
	parameter int IDX_W = 4
) (
	input wire logic sys_clk,
	input wire logic we,
	input wire logic [IDX_W-1:0] waddr,
	input wire logic [W-1:0] wdata,
	input wire logic [IDX_W-1:0] raddr,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem [DEPTH];

	// no reset: validity lives in flops outside
	always_ff @(posedge sys_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

// ---- logic/meat_write_merge.sv ----
`timescale 1ns/10ps
module meat_write_merge
	import meat_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic in_valid,
	input wire logic in_merge,
	input wire logic [31:0] in_addr,
	input wire logic [63:0] in_data,
	input wire logic [7:0] in_be,
	output meat_wr_t out_wr
);
	typedef struct packed {
		meat_wr_t hold;
		logic sealed;
		logic [2:0] idle;
		meat_wr_t out;
	} meat_wm_state_t;
	meat_wm_state_t s_r, s_nxt;
	logic same;

	// only open, mergeable entries of one qword absorb later writes,
	// so write order on the bus is never changed
	always_comb begin
		s_nxt = s_r;
		s_nxt.out.valid = 1'b0;
		same = s_r.hold.valid & !s_r.sealed & in_merge
			& (s_r.hold.qaddr == in_addr[31:3]);
		if (in_valid && same) begin
			for (int i = 0; i < 8; i++) begin
				if (in_be[i]) begin
					s_nxt.hold.data[i*8 +: 8] = in_data[i*8 +: 8];
				end
			end
			s_nxt.hold.be = s_r.hold.be | in_be;
			s_nxt.idle = 3'h0;
		end else if (in_valid) begin
			s_nxt.out = s_r.hold;
			s_nxt.hold.valid = 1'b1;
			s_nxt.hold.qaddr = in_addr[31:3];
			s_nxt.hold.data = in_data;
			s_nxt.hold.be = in_be;
			s_nxt.sealed = !in_merge;
			s_nxt.idle = 3'h0;
		end else if (s_r.hold.valid) begin
			// unmergeable writes leave at once, open ones after a pause
			if (s_r.sealed || 32'(s_r.idle) == MERGE_HOLD_CYCLES - 1) begin
				s_nxt.out = s_r.hold;
				s_nxt.hold.valid = 1'b0;
			end else begin
				s_nxt.idle = s_r.idle + 3'h1;
			end
		end
	end

	// state register
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign out_wr = s_r.out;
endmodule

// ---- logic/meat_translate.sv ----
`timescale 1ns/10ps
module meat_translate
	import meat_pkg::*;
#(
	parameter int TLB_DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input meat_req_t req,
	output logic req_ready,
	output meat_resp_t resp,
	output logic walk_req_valid,
	output logic [31:0] walk_req_addr,
	input meat_walk_t walk_rsp,
	output meat_wr_t wr_out
);
	localparam int IDX_W = $clog2(TLB_DEPTH);
	localparam int ENT_W = $bits(meat_tlb_ent_t);

	typedef struct packed {
		meat_state_t st;
		meat_req_t q;
		logic [TLB_DEPTH-1:0] vld;
		logic [2:0] cfg;
		logic [1:0] lebc;
		logic [1:0] gebc;
		meat_fault_t last_fault;
		meat_resp_t resp;
		logic walk_req;
		logic [31:0] walk_addr;
		logic req_ready;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} meat_state_all_t;

	meat_state_all_t s_r, s_nxt;
	meat_mmu_mode_t mmu_mode;
	meat_req_t cur;
	meat_tlb_ent_t ent, fill;
	logic take;
	logic hit;
	logic fin;
	logic push_wr;
	logic mem_we;
	logic apb_wr;
	logic [IDX_W-1:0] idx_q;
	logic [IDX_W-1:0] raddr;
	logic [ENT_W-1:0] rdata;
	logic src_ok;
	logic src_first;
	logic [31:0] src_pte;
	logic src_readable;
	logic src_single;
	logic [PAGE_MASK_W-1:0] src_mask;
	logic [31:0] keep;
	logic [1:0] eb_mode;
	meat_cache_mode_t b_mode;
	logic b_alloc;
	meat_fault_t b_fault;
	logic [63:0] b_res;

	// mode decode from the configuration value
	always_comb begin
		if (s_r.cfg == CFG_ACTIVE) begin
			mmu_mode = mmu_active;
		end else if (s_r.cfg == CFG_ENHANCED_BYPASS) begin
			mmu_mode = mmu_enhanced;
		end else begin
			mmu_mode = mmu_bypass;
		end
	end

	// request path: a new request in idle, else the held one
	assign take = req.valid & s_r.req_ready;
	assign cur = (s_r.st == st_idle) ? req : s_r.q;
	assign idx_q = s_r.q.addr[PTE_BASE_LSB +: IDX_W];
	assign raddr = take ? req.addr[PTE_BASE_LSB +: IDX_W] : idx_q;
	assign ent = meat_tlb_ent_t'(rdata);
	assign hit = s_r.vld[idx_q]
		& (ent.tag == s_r.q.addr[31:PTE_BASE_LSB]);
	assign apb_wr = psel & penable & pwrite & s_r.pready & !s_r.pslverr;

	// fill entry straight from the walker answer
	always_comb begin
		fill.tag = s_r.q.addr[31:PTE_BASE_LSB];
		fill.pte = walk_rsp.pte;
		fill.readable = walk_rsp.readable;
		fill.single_use = walk_rsp.single_use;
		fill.mask = walk_rsp.mask;
	end

	// enhanced bypass picks its cache mode by local or global range
	always_comb begin
		if (mmu_mode != mmu_enhanced) begin
			eb_mode = cache_mode_uncached;
		end else if (cur.addr[GLOBAL_RANGE_BIT]) begin
			eb_mode = s_r.gebc;
		end else begin
			eb_mode = s_r.lebc;
		end
	end

	// choose where the mapping of this cycle's finishing request is from
	always_comb begin
		fin = 1'b0;
		src_ok = 1'b0;
		src_first = 1'b0;
		src_pte = '0;
		src_readable = 1'b0;
		src_single = 1'b0;
		src_mask = '1;
		case (s_r.st)
			st_idle: begin
				// no translation outside active mode: identity mapping
				fin = take & (mmu_mode != mmu_active);
				src_ok = 1'b1;
				src_pte = {cur.addr[31:PTE_BASE_LSB], 4'h0, eb_mode,
					1'b0, BYPASS_CTRL_BITS};
				src_readable = 1'b1;
			end
			st_lookup: begin
				fin = hit;
				src_ok = ent.pte[ENTRY_VALID_BIT];
				src_pte = ent.pte;
				src_readable = ent.readable;
				src_single = ent.single_use;
				src_mask = ent.mask;
			end
			st_walk: begin
				fin = walk_rsp.valid;
				src_ok = walk_rsp.l1_valid
					& walk_rsp.pte[ENTRY_VALID_BIT];
				src_first = !walk_rsp.l1_valid;
				src_pte = walk_rsp.pte;
				src_readable = walk_rsp.readable;
				src_single = walk_rsp.single_use;
				src_mask = walk_rsp.mask;
			end
			default: begin
				fin = 1'b0;
			end
		endcase
	end

	// cache allocation from the entry's mode and the set's lock state
	always_comb begin
		b_mode = meat_cache_mode_t'(src_pte[PTE_MODE_LSB +: 2]);
		b_alloc = (b_mode != cache_mode_uncached);
		if (b_mode == cache_mode_single_way
			&& cur.lock_mask[cur.thread]) begin
			b_alloc = 1'b0;
		end
		if (b_mode == cache_mode_full && &cur.lock_mask) begin
			b_alloc = 1'b0;
		end
	end

	// access checks; a lookup instruction itself never faults
	always_comb begin
		if (cur.lookup) begin
			b_fault = fault_none;
		end else if (!src_ok) begin
			b_fault = fault_invalid;
		end else if (cur.write && !src_pte[ENTRY_WRITE_ENABLE_BIT]) begin
			b_fault = fault_write;
		end else if (src_pte[ENTRY_PRIVILEGED_ONLY_BIT] && !cur.privileged_only) begin
			b_fault = fault_privileged_only;
		end else if (!cur.write && !src_readable) begin
			b_fault = fault_read;
		end else if (src_pte[ENTRY_EXCLUSIVE_SCOPE_BIT] && !cur.claimed) begin
			b_fault = fault_claim;
		end else begin
			b_fault = fault_none;
		end
	end

	// packed lookup result; undefined fields of a miss read zero
	always_comb begin
		b_res = '0;
		if (src_ok) begin
			b_res = {16'h0000, src_mask, 1'b0, src_single, 1'b0,
				src_readable, src_pte};
		end else begin
			b_res[LOOKUP_FIRST_BIT] = src_first;
		end
		// mask bits keep the entry base, clear ones pass linear bits
		keep = {MASK_TOP_KEEP, src_mask, 12'h000};
	end

	assign push_wr = fin & cur.write & !cur.lookup & (b_fault == fault_none);

	// main sequencing, register bus and TLB bookkeeping
	always_comb begin
		s_nxt = s_r;
		s_nxt.resp.valid = 1'b0;
		s_nxt.walk_req = 1'b0;
		mem_we = 1'b0;
		case (s_r.st)
			st_idle: begin
				if (take) begin
					s_nxt.q = req;
					if (mmu_mode == mmu_active) begin
						s_nxt.st = st_lookup;
						s_nxt.req_ready = 1'b0;
					end
				end
			end
			st_lookup: begin
				if (hit) begin
					if (ent.single_use) begin
						s_nxt.vld[idx_q] = 1'b0;
					end
				end else begin
					s_nxt.walk_req = 1'b1;
					s_nxt.walk_addr = s_r.q.addr;
					s_nxt.st = st_walk;
				end
			end
			st_walk: begin
				if (walk_rsp.valid) begin
					// invalid mappings are never kept, a retry refetches
					if (src_ok) begin
						mem_we = 1'b1;
						s_nxt.vld[idx_q] = 1'b1;
					end
				end
			end
			default: begin
				s_nxt.st = st_idle;
			end
		endcase

		// answer the finishing request
		if (fin) begin
			s_nxt.st = st_idle;
			s_nxt.req_ready = 1'b1;
			s_nxt.last_fault = b_fault;
			s_nxt.resp.valid = 1'b1;
			s_nxt.resp.fault = b_fault;
			s_nxt.resp.paddr = (src_pte & keep)
				| (cur.addr & ~keep);
			s_nxt.resp.burst_read = (b_mode != cache_mode_uncached);
			s_nxt.resp.cache_alloc = b_alloc;
			s_nxt.resp.alloc_transient =
				(b_mode == cache_mode_transient);
			s_nxt.resp.alloc_way_only =
				(b_mode == cache_mode_single_way);
			s_nxt.resp.alloc_way = cur.thread;
			s_nxt.resp.write_merge_allowed =
				src_pte[ENTRY_WRITE_MERGE_BIT];
			s_nxt.resp.exclusive_system_scope =
				src_pte[ENTRY_EXCLUSIVE_SCOPE_BIT];
			s_nxt.resp.system_coherent_flag =
				src_pte[ENTRY_EXCLUSIVE_SCOPE_BIT];
			s_nxt.resp.result = b_res;
		end

		// apb: answer in the first access cycle, data staged at setup
		s_nxt.pready = psel & !penable;
		s_nxt.pslverr = 1'b0;
		s_nxt.prdata = '0;
		if (psel && !penable) begin
			case (paddr)
				OFS_TRANSLATION_MODE_CONFIG: begin
					s_nxt.prdata = {29'h0, s_r.cfg};
				end
				OFS_LOCAL_BYPASS_CACHE_CTRL: begin
					s_nxt.prdata = {30'h0, s_r.lebc};
				end
				OFS_GLOBAL_BYPASS_CACHE_CTRL: begin
					s_nxt.prdata = {30'h0, s_r.gebc};
				end
				OFS_TLB_FLUSH: begin
					s_nxt.prdata = '0;
				end
				OFS_STATUS: begin
					s_nxt.prdata = {26'h0, s_r.st != st_idle,
						s_r.last_fault, mmu_mode};
				end
				default: begin
					s_nxt.pslverr = 1'b1;
				end
			endcase
		end
		if (apb_wr) begin
			case (paddr)
				OFS_TRANSLATION_MODE_CONFIG: begin
					s_nxt.cfg = pwdata[2:0];
				end
				OFS_LOCAL_BYPASS_CACHE_CTRL: begin
					s_nxt.lebc = pwdata[1:0];
				end
				OFS_GLOBAL_BYPASS_CACHE_CTRL: begin
					s_nxt.gebc = pwdata[1:0];
				end
				OFS_TLB_FLUSH: begin
					// flush wins over a same-cycle fill: stale is worse
					s_nxt.vld = '0;
				end
				default: begin
					s_nxt.vld = s_nxt.vld;
				end
			endcase
		end
	end

	// state register; reset leaves the unit in bypass mode
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '0;
			s_r.cfg <= CFG_RESET;
			s_r.req_ready <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	meat_tlb_mem #(
		.W(ENT_W),
		.DEPTH(TLB_DEPTH),
		.IDX_W(IDX_W)
	) u_tlb_mem (
		.sys_clk(sys_clk),
		.we(mem_we),
		.waddr(idx_q),
		.wdata(fill),
		.raddr(raddr),
		.rdata(rdata)
	);

	meat_write_merge u_merge (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.in_valid(push_wr),
		.in_merge(src_pte[ENTRY_WRITE_MERGE_BIT]),
		.in_addr(s_nxt.resp.paddr),
		.in_data(cur.wdata),
		.in_be(cur.be),
		.out_wr(wr_out)
	);

	// outputs straight from flops
	assign pready = s_r.pready;
	assign prdata = s_r.prdata;
	assign pslverr = s_r.pslverr;
	assign req_ready = s_r.req_ready;
	assign resp = s_r.resp;
	assign walk_req_valid = s_r.walk_req;
	assign walk_req_addr = s_r.walk_addr;
endmodule

// ---- verification/meat_translate_chk.sv ----
`timescale 1ns/10ps
module meat_translate_chk
	import meat_pkg::*;
#(
	parameter int TLB_DEPTH = 16
) (
	input logic sys_clk,
	input logic rst_b,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	input logic pready,
	input logic [31:0] prdata,
	input logic pslverr,
	input meat_req_t req,
	input logic req_ready,
	input meat_resp_t resp,
	input logic walk_req_valid,
	input logic [31:0] walk_req_addr,
	input meat_walk_t walk_rsp,
	input meat_wr_t wr_out
);
	meat_req_t tk_r;
	logic [2:0] cfg_r;
	logic ans;
	// shadow of the request being answered and of the mode word
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tk_r <= '0;
			cfg_r <= CFG_RESET;
		end else begin
			if (req.valid && req_ready)
				tk_r <= req;
			if (psel && penable && pwrite && paddr == OFS_TRANSLATION_MODE_CONFIG)
				cfg_r <= pwdata[2:0];
		end
	end
	// answers to ordinary accesses, lookups excluded
	assign ans = resp.valid && !tk_r.lookup;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	chk_apb_zero_wait: assert property (psel && !penable |=> pready)
		else $error("apb access not answered at once");
	chk_bypass_flat: assert property (
		ans && cfg_r != CFG_ENHANCED_BYPASS && cfg_r != CFG_ACTIVE
		|-> resp.paddr == tk_r.addr && !resp.cache_alloc)
		else $error("bypass access altered or cached");
	chk_enhanced_flat: assert property (
		ans && cfg_r == CFG_ENHANCED_BYPASS |-> resp.paddr == tk_r.addr)
		else $error("enhanced bypass translated an address");
	chk_offset_kept: assert property (
		ans && resp.fault == fault_none
		|-> resp.paddr[11:0] == tk_r.addr[11:0])
		else $error("page offset not taken from linear address");
	chk_alloc_way: assert property (ans |-> resp.alloc_way == tk_r.thread)
		else $error("allocation way differs from thread");
	chk_uncached_read: assert property (
		ans && resp.fault == fault_none && !tk_r.write && !resp.burst_read
		|-> !resp.cache_alloc)
		else $error("single read allocated a line");
	chk_claim_needed: assert property (
		ans && resp.system_coherent_flag && !tk_r.claimed
		|-> resp.fault != fault_none)
		else $error("coherent access passed without claim");
	chk_plain_write: assert property (
		ans && tk_r.write && resp.fault == fault_none
		&& !resp.write_merge_allowed
		|=> wr_out.valid && wr_out.qaddr == 29'($past(resp.paddr) >> 3))
		else $error("plain write not issued next cycle");
	chk_lookup_miss: assert property (
		resp.valid && tk_r.lookup && !resp.result[0]
		|-> resp.result[63:3] == '0 && !resp.result[1])
		else $error("failed lookup word has stray bits");
	chk_lookup_zero: assert property (
		resp.valid && tk_r.lookup && resp.result[0]
		|-> resp.result[63:48] == 16'h0 && !resp.result[35] && !resp.result[33])
		else $error("lookup reserved bits not zero");
	chk_walk_addr: assert property (
		walk_req_valid |-> walk_req_addr == tk_r.addr)
		else $error("walk started for another address");
	cover property (walk_req_valid);
	cover property (resp.valid && resp.fault == fault_read);
	cover property (resp.valid && tk_r.lookup);
	cover property (wr_out.valid);
endmodule
bind meat_translate meat_translate_chk #(.TLB_DEPTH(TLB_DEPTH)) u_chk (
	.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
	.prdata, .pslverr, .req, .req_ready, .resp, .walk_req_valid,
	.walk_req_addr, .walk_rsp, .wr_out);

// ---- verification/meat_walk_model.sv ----
`timescale 1ns/10ps
module meat_walk_model
	import meat_pkg::*;
(
	input logic sys_clk,
	input logic rst_b,
	input logic walk_req_valid,
	input logic [31:0] pte,
	input logic l1_valid,
	input logic [3:0] dly,
	input logic [1:0] flags,
	output meat_walk_t walk_rsp
);
	logic busy_r;
	logic [3:0] cnt_r;
	initial walk_rsp = '0;
	// reply dly+1 cycles after the edge that sees each walk; idle fields churn so stale data
	// can never pass for an answer
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			busy_r <= 1'h0;
			cnt_r <= 4'h0;
			walk_rsp <= '0;
		end else begin
			walk_rsp <= ~walk_rsp;
			walk_rsp.valid <= 1'h0;
			if (walk_req_valid) begin
				busy_r <= 1'h1;
				cnt_r <= dly;
			end else if (busy_r && cnt_r != 4'h0) begin
				cnt_r <= cnt_r - 4'h1;
			end else if (busy_r) begin
				busy_r <= 1'h0;
				// flags[1] readable, flags[0] single-use
				walk_rsp <= '{valid: 1'h1, l1_valid: l1_valid, pte: pte,
					readable: flags[1], single_use: flags[0], mask: '1};
			end
		end
	end
endmodule

// ---- verification/meat_translate_tb.sv ----
`timescale 1ns/10ps
module meat_translate_tb;
	import meat_pkg::*;
	typedef struct packed {
		logic [31:0] pte;
		logic wr;
		logic pv;
		logic cl;
		logic [3:0] lk;
		meat_fault_t flt;
	} meat_row_t;
	logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, se;
	logic req_ready, walk_req_valid, l1v, ea;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, pte, rd, a, walk_req_addr;
	logic [3:0] dly;
	logic [1:0] fl;
	logic [63:0] wd = 64'h0123456789abcdef;
	logic [7:0] wb = 8'hff;
	meat_wr_t wlast;
	logic [1:0] m;
	meat_req_t req;
	meat_resp_t resp;
	meat_walk_t walk_rsp;
	meat_wr_t wr_out;
	int err_total, n_tests, cyc, walks, wrs, w0;
	meat_row_t rows [13] = '{
		'{32'h000a1002, 1'h0, 1'h1, 1'h1, 4'h0, fault_invalid},
		'{32'h000a20c3, 1'h1, 1'h1, 1'h1, 4'h0, fault_none},
		'{32'h000a30c1, 1'h1, 1'h1, 1'h1, 4'h0, fault_write},
		'{32'h000a40c5, 1'h0, 1'h0, 1'h1, 4'h0, fault_privileged_only},
		'{32'h000a50c5, 1'h0, 1'h1, 1'h1, 4'h0, fault_none},
		'{32'h000a60d1, 1'h0, 1'h1, 1'h0, 4'h0, fault_claim},
		'{32'h000a70d1, 1'h0, 1'h1, 1'h1, 4'h0, fault_none},
		'{32'h000a8001, 1'h0, 1'h1, 1'h1, 4'h0, fault_none},
		'{32'h000a9041, 1'h0, 1'h1, 1'h1, 4'h0, fault_none},
		'{32'h000aa081, 1'h0, 1'h1, 1'h1, 4'h0, fault_none},
		'{32'h000ab081, 1'h0, 1'h1, 1'h1, 4'h4, fault_none},
		'{32'h000ac0c1, 1'h0, 1'h1, 1'h1, 4'h7, fault_none},
		'{32'h000ad0c1, 1'h0, 1'h1, 1'h1, 4'hf, fault_none}};

	meat_translate dut (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pready, .prdata, .pslverr, .req, .req_ready, .resp,
		.walk_req_valid, .walk_req_addr, .walk_rsp, .wr_out);
	meat_walk_model walker (.sys_clk, .rst_b, .walk_req_valid, .pte,
		.l1_valid(l1v), .dly, .flags(fl), .walk_rsp);

	task automatic test_done();
		if (err_total == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer; read data and error taken at the ready edge
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		do @(posedge sys_clk); while (pready !== 1'h1);
		rd = prdata;
		se = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge sys_clk);
	endtask
	// one request, held until taken, then wait for its answer
	task automatic xlate(input logic [31:0] ad, input logic w, pv, cl, lu,
		input logic [1:0] th, input logic [3:0] lk);
		req <= '{1'h1, lu, w, pv, cl, th, lk, ad, wd, wb};
		do @(posedge sys_clk); while (req_ready !== 1'h1);
		req.valid <= 1'h0;
		do @(posedge sys_clk); while (resp.valid !== 1'h1);
	endtask

	initial begin
		sys_clk = 1'h0;
		forever #4 sys_clk = ~sys_clk;
	end
	// cycle budget, walk and write-out counters
	always @(posedge sys_clk) begin
		cyc++;
		walks += int'(walk_req_valid === 1'h1);
		wrs += int'(wr_out.valid === 1'h1);
		if (wr_out.valid === 1'h1)
			wlast = wr_out;
		if (cyc == 5000) begin
			err_total++;
			test_done();
		end
	end

	initial begin
		rst_b = 1'h0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		req = '0;
		pte = 32'h0;
		l1v = 1'h1;
		dly = 4'h0;
		fl = 2'h2;
		repeat (20) @(posedge sys_clk);
		rst_b <= 1'h1;
		@(posedge sys_clk);
		apb(1'h0, OFS_STATUS, 32'h0);
		check(rd, 32'h0);
		xlate(32'h40001234, 1'h0, 1'h0, 1'h1, 1'h0, 2'h1, 4'h0);
		check({resp.paddr, resp.cache_alloc}, {32'h40001234, 1'h0});
		apb(1'h1, 12'hff0, 32'h7);
		check(se, 1'h1);
		apb(1'h1, OFS_TRANSLATION_MODE_CONFIG, 32'h6);
		apb(1'h1, OFS_LOCAL_BYPASS_CACHE_CTRL, 32'h3);
		xlate(32'h40002000, 1'h0, 1'h0, 1'h1, 1'h0, 2'h2, 4'h0);
		check({resp.paddr, resp.cache_alloc}, {32'h40002000, 1'h1});
		check(walks, 0);
		// global range takes its mode from the other control word
		apb(1'h1, OFS_GLOBAL_BYPASS_CACHE_CTRL, 32'h1);
		xlate(32'hc0003000, 1'h0, 1'h0, 1'h1, 1'h0, 2'h3, 4'h0);
		check({resp.paddr, resp.cache_alloc, resp.alloc_transient},
			{32'hc0003000, 2'h3});
		apb(1'h1, OFS_TRANSLATION_MODE_CONFIG, 32'h7);
		apb(1'h0, OFS_STATUS, 32'h0);
		check(rd[1:0], 2'h2);
		// attribute table: one fresh page per row, walker speed varies
		for (int i = 0; i < 13; i++) begin
			pte = rows[i].pte;
			dly = 4'(i % 3);
			a = 32'h40000458 + (32'(i) << 12);
			m = pte[7:6];
			ea = m == 2'h1 || (m == 2'h2 && !rows[i].lk[i % 4])
				|| (m == 2'h3 && rows[i].lk != 4'hf);
			xlate(a, rows[i].wr, rows[i].pv, rows[i].cl, 1'h0, 2'(i), rows[i].lk);
			check(resp.fault, rows[i].flt);
			if (rows[i].flt == fault_none)
				check(resp.paddr, {pte[31:12], a[11:0]});
			if (rows[i].flt == fault_none && !rows[i].wr)
				check({resp.burst_read, resp.cache_alloc, resp.alloc_transient,
					resp.alloc_way_only, resp.write_merge_allowed,
					resp.system_coherent_flag, resp.exclusive_system_scope},
					{m != 2'h0, ea, m == 2'h1, m == 2'h2, pte[3], pte[4],
					pte[4]});
		end
		pte = rows[0].pte;
		w0 = walks;
		xlate(32'h40000458, 1'h0, 1'h1, 1'h1, 1'h0, 2'h0, 4'h0);
		check(walks - w0, 1);
		pte = rows[4].pte;
		w0 = walks;
		xlate(32'h40004458, 1'h0, 1'h1, 1'h1, 1'h0, 2'h0, 4'h0);
		check(walks - w0, 0);
		apb(1'h1, OFS_TLB_FLUSH, 32'h1);
		xlate(32'h40004458, 1'h0, 1'h1, 1'h1, 1'h0, 2'h0, 4'h0);
		check(walks - w0, 1);
		pte = 32'h000b0fe3;
		xlate(32'h40100abc, 1'h0, 1'h1, 1'h1, 1'h1, 2'h0, 4'h0);
		check(resp.result, {16'h0, 12'hfff, 4'h1, pte});
		pte = 32'h000b1000;
		l1v = 1'h0;
		xlate(32'h40200000, 1'h0, 1'h1, 1'h1, 1'h1, 2'h0, 4'h0);
		check({resp.result[2], resp.result[0]}, 2'h2);
		l1v = 1'h1;
		xlate(32'h40300000, 1'h0, 1'h1, 1'h1, 1'h1, 2'h0, 4'h0);
		check({resp.result[2], resp.result[0]}, 2'h0);
		// two writes to one qword: merged once, else issued twice
		for (int k = 0; k < 2; k++) begin
			pte = k == 0 ? 32'h000c00cb : 32'h000c10c3;
			w0 = wrs;
			wd = 64'h0123456789abcdef;
			wb = 8'h0f;
			xlate(32'h40400010 + (32'(k) << 12), 1'h1, 1'h1, 1'h1, 1'h0, 2'h0, 4'h0);
			wd = 64'hfedcba9876543210;
			wb = 8'hf0;
			xlate(32'h40400010 + (32'(k) << 12), 1'h1, 1'h1, 1'h1, 1'h0, 2'h0, 4'h0);
			repeat (12) @(posedge sys_clk);
			check(wrs - w0, k + 1);
			check(wlast.data, k == 0 ? 64'hfedcba9889abcdef
				: 64'hfedcba9876543210);
			check({wlast.qaddr, wlast.be}, k == 0 ? {29'h18002, 8'hff}
				: {29'h18202, 8'hf0});
		end
		// unreadable, unwritable single-use page: read faults, dropped after one hit
		pte = 32'h000d0001;
		fl = 2'h1;
		w0 = walks;
		xlate(32'h40500000, 1'h0, 1'h1, 1'h1, 1'h0, 2'h0, 4'h0);
		check(resp.fault, fault_read);
		xlate(32'h40500000, 1'h0, 1'h1, 1'h1, 1'h1, 2'h0, 4'h0);
		check(resp.result, {16'h0, 12'hfff, 4'h4, pte});
		xlate(32'h40500000, 1'h0, 1'h1, 1'h1, 1'h0, 2'h0, 4'h0);
		check(walks - w0, 2);
		test_done();
	end
endmodule
